/* File: delivery_batch_controller.sv */
// Delivery sequencing: start/stop and preset modes, relays, end of delivery,
// tickets, clearable minimum, overflow and power loss.
// Assumes pulses and keys are pin levels; totals arithmetic is done here
// by plain counting, one unit per qualified pulse.
// Contract
// - Probe or pulser fault in start/stop mode opens relay one, alternates display.
// - After a fault, flow keeps totalising on remaining channel or last temperature.
// - No flow beyond three minutes completes the delivery and prints a ticket.
// - Flow after end of delivery auto-resets: clear, number up, relay stays open.
// - Two-second reset hold starts delivery; no flow in three minutes ends it.
// - Preset mode opens both relays when the total reaches the batch.
// - Preset delivery completes after batch reached and signal timeout expired.
// - Preset stop key opens both relays; ends after timeout.
// - End-of-delivery output stays on until the next reset.
// - Batch compares gross or net as configured; both cleared at start.
// - Printer enabled: auto ticket at end; reset refused until printed.
// - First ticket original, later stop presses duplicate; none after new start.
// - Printing message shown while ticket data is being sent.
// - Signal timeout on pulse arrival detects stop; overrun keeps totalising.
// - Three-minute timer ends the load, counts delivery, may be disabled.
// - Pulse rates below cutoff count as no flow.
// - Clearable minimum is zero to ninety-nine units; zero disables it.
// - Total below minimum is zeroed, accumulated restored, no ticket.
// - Flow after end before ticket completes is overflow, finish total only.
// - When overflow flow stops, retry the ticket and clear the error.
// - Power loss is end of delivery; on return print original, allow duplicates.
// - Start/stop mode stop key opens only relay one; relay two unused.
`timescale 1ns/1ps
`default_nettype none
module delivery_batch_controller #(
    parameter int unsigned HOLD_LIMIT = delivery_pkg::HOLD_CYCLES,
    parameter int unsigned NOFLOW_LIMIT = delivery_pkg::NOFLOW_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Pins: pulser channels, probe fault, keys, power good
    input wire logic i_pulse_a,
    input wire logic i_pulse_b,
    input wire logic i_probe_fault,
    input wire logic i_key_reset,
    input wire logic i_key_stop,
    input wire logic i_power_good,
    // Configuration
    input wire logic i_preset_mode,
    input wire logic i_dual_input,
    input wire logic i_batch_on_net,
    input wire logic i_printer_en,
    input wire logic i_noflow_timer_en,
    input wire logic [delivery_pkg::TMO_W-1:0] i_signal_timeout,
    input wire logic [delivery_pkg::CNT_W-1:0] i_cutoff_period,
    input wire logic [delivery_pkg::TOTAL_W-1:0] i_batch_qty,
    input wire logic [delivery_pkg::MIN_W-1:0] i_clear_min,
    input wire logic i_net_unit,
    // Printer handshake
    input wire logic i_print_done,
    output logic o_print_req,
    output logic o_print_duplicate,
    output logic [7:0] o_ticket_status,
    // Relays and end-of-delivery output
    output logic o_relay1,
    output logic o_relay2,
    output logic o_eod,
    // Display and indicators
    output logic o_printing_msg,
    output logic o_no_delivery_message,
    output logic o_fault_active,
    output logic [7:0] o_fault_code_display,
    output logic o_reset_led,
    // Totals
    output logic [delivery_pkg::TOTAL_W-1:0] o_gross_total,
    output logic [delivery_pkg::TOTAL_W-1:0] o_net_total,
    output logic [delivery_pkg::TOTAL_W-1:0] o_acc_total,
    output logic [delivery_pkg::DELNO_W-1:0] o_delivery_no
);
    localparam int unsigned TW = delivery_pkg::TOTAL_W;

    delivery_pkg::state_t state;
    delivery_pkg::state_t next_state;

    logic [5:0] pins;
    wire [5:0] pins_raw = {i_power_good, i_key_stop, i_key_reset,
                           i_probe_fault, i_pulse_b, i_pulse_a};

    sync2 #(.W(6)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    logic pa_d, pb_d, stop_d, pg_d;
    logic [delivery_pkg::CNT_W-1:0] since_pulse;
    logic [TW-1:0] acc_start;
    logic original_done, dup_allowed, batch_hit, stop_pressed, fault_seen;
    logic chan_fault, powered_down;

    wire edge_a = pins[0] && !pa_d;
    wire edge_b = pins[1] && !pb_d;
    wire stop_press = pins[4] && !stop_d;
    wire power_lost = !pins[5] && pg_d;
    wire power_back = pins[5] && !pg_d;
    wire probe_fault = pins[2];

    // Dual input verifies by pairing; a dead channel falls back to the other
    wire raw_pulse = (i_dual_input && !chan_fault) ? edge_a : (edge_a || edge_b);
    // Pulses spaced longer than the cutoff period read as zero flow
    wire pulse = raw_pulse && (since_pulse < i_cutoff_period);

    wire running = (state == delivery_pkg::ST_RUN)
                || (state == delivery_pkg::ST_STOPPING);
    wire flow_tmo, noflow_tmo, hold_done;

    tick_timer #(.W(delivery_pkg::TMO_W)) u_sig_tmo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_restart(pulse),
        .i_enable(1'b1),
        .i_limit(i_signal_timeout),
        .o_done(flow_tmo)
    );

    tick_timer #(.W(delivery_pkg::CNT_W)) u_noflow (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_restart(pulse),
        .i_enable(running && i_noflow_timer_en),
        .i_limit(NOFLOW_LIMIT[delivery_pkg::CNT_W-1:0]),
        .o_done(noflow_tmo)
    );

    tick_timer #(.W(delivery_pkg::CNT_W)) u_hold (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_restart(1'b0),
        .i_enable(pins[3]),
        .i_limit(HOLD_LIMIT[delivery_pkg::CNT_W-1:0]),
        .o_done(hold_done)
    );

    logic hold_seen;
    wire start_req = hold_done && !hold_seen;
    // Busy ticket blocks a new start
    wire start_ok = start_req && (state != delivery_pkg::ST_PRINT)
                 && (state != delivery_pkg::ST_OVERFLOW);

    wire [TW-1:0] batch_total = i_batch_on_net ? o_net_total : o_gross_total;
    wire batch_reached = i_preset_mode && (batch_total >= i_batch_qty);
    wire [TW-1:0] clear_min = {{(TW-delivery_pkg::MIN_W){1'b0}},
        (i_clear_min > delivery_pkg::CLR_MIN_MAX) ? delivery_pkg::CLR_MIN_MAX
                                                  : i_clear_min};
    localparam logic [TW-1:0] TOTAL_ZERO = delivery_pkg::TOTAL_RESET;
    wire below_min = (clear_min != TOTAL_ZERO) && (o_gross_total < clear_min);

    wire end_cond = noflow_tmo
        || (flow_tmo && (stop_pressed || batch_hit));
    wire end_now = running && (end_cond || power_lost);
    wire print_needed = i_printer_en && !below_min;

    always_comb begin
        next_state = state;
        case (state)
            delivery_pkg::ST_IDLE: begin
                if (start_ok) begin
                    next_state = delivery_pkg::ST_RUN;
                end
            end
            delivery_pkg::ST_RUN, delivery_pkg::ST_STOPPING: begin
                if (end_now) begin
                    // No printer power on a loss: ticket waits for return
                    next_state = (print_needed && !power_lost)
                        ? delivery_pkg::ST_PRINT
                        : delivery_pkg::ST_DONE;
                end else if (stop_press || batch_reached || fault_seen) begin
                    next_state = delivery_pkg::ST_STOPPING;
                end
            end
            delivery_pkg::ST_PRINT: begin
                if (pulse) begin
                    next_state = delivery_pkg::ST_OVERFLOW;
                end else if (i_print_done) begin
                    next_state = delivery_pkg::ST_DONE;
                end
            end
            delivery_pkg::ST_OVERFLOW: begin
                if (flow_tmo) begin
                    next_state = delivery_pkg::ST_PRINT;
                end
            end
            delivery_pkg::ST_DONE: begin
                if (start_ok || pulse) begin
                    next_state = delivery_pkg::ST_RUN;
                end else if (stop_press && dup_allowed && i_printer_en) begin
                    next_state = delivery_pkg::ST_PRINT;
                end else if (power_back && powered_down && print_needed) begin
                    next_state = delivery_pkg::ST_PRINT;
                end
            end
            default: begin
                next_state = delivery_pkg::ST_IDLE;
            end
        endcase
    end

    wire entering_run = (next_state == delivery_pkg::ST_RUN)
                     && (state != delivery_pkg::ST_RUN);
    wire auto_reset = entering_run && !start_ok;
    wire reach_end = end_now;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= delivery_pkg::ST_IDLE;
            pa_d <= 1'b0;
            pb_d <= 1'b0;
            stop_d <= 1'b0;
            // Matches the synchroniser's reset, so no false power loss
            pg_d <= 1'b0;
            since_pulse <= '0;
            hold_seen <= 1'b0;
            o_gross_total <= delivery_pkg::TOTAL_RESET;
            o_net_total <= delivery_pkg::TOTAL_RESET;
            o_acc_total <= delivery_pkg::TOTAL_RESET;
            acc_start <= delivery_pkg::TOTAL_RESET;
            o_delivery_no <= delivery_pkg::DELNO_RESET;
            o_relay1 <= 1'b0;
            o_relay2 <= 1'b0;
            o_eod <= 1'b0;
            o_reset_led <= 1'b0;
            original_done <= 1'b0;
            dup_allowed <= 1'b0;
            batch_hit <= 1'b0;
            stop_pressed <= 1'b0;
            fault_seen <= 1'b0;
            chan_fault <= 1'b0;
            powered_down <= 1'b0;
            o_ticket_status <= 8'h00;
            o_no_delivery_message <= 1'b0;
        end else begin
            state <= next_state;
            pa_d <= pins[0];
            pb_d <= pins[1];
            stop_d <= pins[4];
            pg_d <= pins[5];
            since_pulse <= raw_pulse ? '0 :
                (&since_pulse ? since_pulse : since_pulse + 32'h1);
            hold_seen <= pins[3] ? (hold_seen || hold_done) : 1'b0;
            // Dual input with one channel silent marks a pulser fault
            if (i_dual_input && (edge_a != edge_b) && running) begin
                chan_fault <= 1'b1;
            end
            if (entering_run) begin
                o_gross_total <= TOTAL_ZERO;
                o_net_total <= TOTAL_ZERO;
                acc_start <= o_acc_total;
                o_delivery_no <= o_delivery_no + 16'h1;
                o_relay1 <= !auto_reset;
                o_relay2 <= !auto_reset && i_preset_mode;
                o_eod <= 1'b0;
                o_reset_led <= 1'b1;
                original_done <= 1'b0;
                dup_allowed <= 1'b0;
                batch_hit <= 1'b0;
                stop_pressed <= 1'b0;
                fault_seen <= 1'b0;
                chan_fault <= 1'b0;
                o_ticket_status <= 8'h00;
                o_no_delivery_message <= 1'b0;
            end else if (running) begin
                if (pulse) begin
                    o_gross_total <= o_gross_total + 32'h1;
                    o_acc_total <= o_acc_total + 32'h1;
                    // Net follows the last good temperature factor
                    if (i_net_unit) begin
                        o_net_total <= o_net_total + 32'h1;
                    end
                end
                if ((probe_fault || chan_fault) && !i_preset_mode) begin
                    fault_seen <= 1'b1;
                    o_relay1 <= 1'b0;
                end
                if (stop_press) begin
                    stop_pressed <= 1'b1;
                    o_relay1 <= 1'b0;
                    o_relay2 <= 1'b0;
                end
                if (batch_reached) begin
                    batch_hit <= 1'b1;
                    o_relay1 <= 1'b0;
                    o_relay2 <= 1'b0;
                end
                if (reach_end) begin
                    o_relay1 <= 1'b0;
                    o_relay2 <= 1'b0;
                    o_eod <= 1'b1;
                    powered_down <= power_lost;
                    if (below_min) begin
                        o_gross_total <= TOTAL_ZERO;
                        o_net_total <= TOTAL_ZERO;
                        o_acc_total <= acc_start;
                    end
                end
            end else begin
                // The pulse that breaks into a ticket counts as overflow too
                if (pulse && (state == delivery_pkg::ST_OVERFLOW
                    || state == delivery_pkg::ST_PRINT)) begin
                    o_acc_total <= o_acc_total + 32'h1;
                end
                if (next_state == delivery_pkg::ST_OVERFLOW) begin
                    o_ticket_status <= delivery_pkg::OVERFLOW_STATUS;
                end
                if (state == delivery_pkg::ST_PRINT && i_print_done) begin
                    original_done <= 1'b1;
                    dup_allowed <= 1'b1;
                end
                if (state == delivery_pkg::ST_DONE && stop_press) begin
                    o_no_delivery_message <= !dup_allowed;
                end
            end
            if (power_back && powered_down) begin
                powered_down <= 1'b0;
            end
        end
    end

    // Ticket replays after power return: the done state re-enters printing
    assign o_print_req = (state == delivery_pkg::ST_PRINT);
    assign o_print_duplicate = original_done;
    assign o_printing_msg = (state == delivery_pkg::ST_PRINT);
    assign o_fault_active = fault_seen
        || (state == delivery_pkg::ST_OVERFLOW);
    assign o_fault_code_display = (state == delivery_pkg::ST_OVERFLOW)
        ? delivery_pkg::FAULT_OVERFLOW
        : {6'h00, chan_fault, probe_fault && fault_seen};
endmodule
`default_nettype wire

/* File: delivery_pkg.sv */
// Constants and types for the delivery batch controller.
// Assumes a 20 MHz system clock.
package delivery_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned HOLD_TIME_MS = 2000;
    localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned NOFLOW_TIME_S = 180;
    localparam int unsigned NOFLOW_CYCLES = NOFLOW_TIME_S * CLK_HZ;
    localparam int unsigned TOTAL_W = 32;
    localparam int unsigned DELNO_W = 16;
    localparam int unsigned TMO_W = 24;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned MIN_W = 7;
    localparam logic [MIN_W-1:0] CLR_MIN_MAX = 7'h63;
    localparam logic [7:0] OVERFLOW_STATUS = 8'hc8;
    localparam logic [7:0] FAULT_OVERFLOW = 8'h0e;
    localparam logic [TOTAL_W-1:0] TOTAL_RESET = 32'h0;
    localparam logic [DELNO_W-1:0] DELNO_RESET = 16'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_STOPPING = 3'b010,
        ST_PRINT = 3'b011,
        ST_DONE = 3'b100,
        ST_OVERFLOW = 3'b101
    } state_t;
endpackage

/* File: tick_timer.sv */
// Restartable cycle counter with a done level.
// Assumes restart and enable come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module tick_timer #(
    parameter int unsigned W = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_restart,
    input wire logic i_enable,
    input wire logic [W-1:0] i_limit,
    // Status
    output logic o_done
);
    logic [W-1:0] count;
    wire at_limit = (count >= i_limit);
    wire [W-1:0] next_count = at_limit ? count : count + {{(W-1){1'b0}}, 1'b1};

    always_ff @(posedge i_clk) begin
        if (i_rst || i_restart || !i_enable) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Limit zero would fire at once, so done needs the enable too
    assign o_done = i_enable && !i_restart && at_limit;
endmodule
`default_nettype wire

/* File: sync2.sv */
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the inputs are slow levels; pulses shorter than one clock may vanish.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: printer_model.sv */
// Behavioural ticket printer on the far side of the print handshake.
// Assumes one ticket per request; the answer is a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none
module printer_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Handshake
    input wire logic i_print_req,
    input wire logic [7:0] i_delay,
    output logic o_print_done
);
    logic [7:0] busy_cnt;
    // Slow delays leave room for overflow flow mid-ticket
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_print_req || o_print_done) begin
            busy_cnt <= 8'h00;
            o_print_done <= 1'b0;
        end else begin
            busy_cnt <= busy_cnt + 8'h01;
            o_print_done <= (busy_cnt == i_delay);
        end
    end
endmodule
`default_nettype wire

/* File: delivery_batch_controller_properties.sv */
// Port-level checker for the delivery batch controller.
// Assumes configuration levels stay still while a delivery runs.
`timescale 1ns/1ps
`default_nettype none
module delivery_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_key_stop,
    input wire logic i_preset_mode,
    input wire logic i_batch_on_net,
    input wire logic [delivery_pkg::TOTAL_W-1:0] i_batch_qty,
    input wire logic o_print_req,
    input wire logic o_print_duplicate,
    input wire logic o_relay1,
    input wire logic o_relay2,
    input wire logic o_eod,
    input wire logic o_printing_msg,
    input wire logic [delivery_pkg::TOTAL_W-1:0] o_gross_total,
    input wire logic [delivery_pkg::TOTAL_W-1:0] o_net_total,
    input wire logic [delivery_pkg::DELNO_W-1:0] o_delivery_no
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_eod_holds: assert property (
        o_eod |=> o_eod || o_delivery_no != $past(o_delivery_no))
        else $error("end of delivery dropped without a new start");
    a_totals_cleared: assert property (
        $changed(o_delivery_no) |-> o_gross_total == '0 && o_net_total == '0)
        else $error("totals not cleared at delivery start");
    a_relay_on_start: assert property (
        $rose(o_relay1) |-> o_delivery_no != $past(o_delivery_no, 2))
        else $error("relay one closed without a new delivery");
    a_stop_opens: assert property (
        $rose(i_key_stop) |-> ##[1:6] !o_relay1 && !o_relay2)
        else $error("stop key did not open the relays");
    a_relay2_unused: assert property (
        !i_preset_mode |=> !o_relay2)
        else $error("relay two closed in start/stop mode");
    a_batch_reached: assert property (
        i_preset_mode && i_batch_qty != '0 && o_relay1
        && (i_batch_on_net ? o_net_total : o_gross_total) >= i_batch_qty
        |-> ##[0:2] !o_relay1 && !o_relay2)
        else $error("relays still closed after batch reached");
    a_print_msg: assert property (
        o_print_req |-> o_printing_msg && o_eod)
        else $error("printing message missing during ticket");
    a_dup_after_end: assert property (
        $rose(o_print_req) && o_print_duplicate |-> o_eod)
        else $error("duplicate ticket outside a finished delivery");
    a_no_start_print: assert property (
        o_print_req |=> $stable(o_delivery_no))
        else $error("delivery started while a ticket was pending");
endmodule
bind delivery_batch_controller delivery_props i_delivery_props (.*);
`default_nettype wire

/* File: delivery_batch_controller_tb.sv */
// Self-checking bench: sequences of key, pulse and printer exchanges.
// Assumes shortened hold and no-flow limits set at the instance.
`timescale 1ns/1ps
`default_nettype none
module delivery_batch_controller_tb;
    logic i_clk = 1'b0, i_rst = 1'b1;
    logic i_pulse_a = 0, i_pulse_b = 0, i_probe_fault = 0, i_key_reset = 0;
    logic i_key_stop = 0, i_power_good = 1, i_preset_mode = 0;
    logic i_dual_input = 0, i_batch_on_net = 0, i_printer_en = 1;
    logic i_noflow_timer_en = 1, i_net_unit = 1, i_print_done;
    logic [delivery_pkg::TMO_W-1:0] i_signal_timeout = 24'h00001e;
    logic [delivery_pkg::CNT_W-1:0] i_cutoff_period = 32'h000003e8;
    logic [delivery_pkg::TOTAL_W-1:0] i_batch_qty = 32'h4;
    logic [delivery_pkg::MIN_W-1:0] i_clear_min = 7'h00;
    logic [7:0] delay = 8'h05, o_ticket_status, o_fault_code_display;
    logic o_print_req, o_print_duplicate, o_relay1, o_relay2, o_eod;
    logic o_printing_msg, o_no_delivery_message, o_fault_active, o_reset_led;
    logic [delivery_pkg::TOTAL_W-1:0] o_gross_total, o_net_total, o_acc_total;
    logic [delivery_pkg::DELNO_W-1:0] o_delivery_no;
    int n_errors = 0, cmp_count = 0;
    logic b_on = 1'b1;
    always #25 i_clk = ~i_clk;
    delivery_batch_controller #(.HOLD_LIMIT(20), .NOFLOW_LIMIT(200))
        i_delivery_batch_controller (.*);
    printer_model i_printer_model (.i_clk(i_clk), .i_rst(i_rst),
        .i_print_req(o_print_req), .i_delay(delay),
        .o_print_done(i_print_done));
    task automatic test_done;
        $display("checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Key held well past the hold limit plus sync delay
    task automatic start_del;
        i_key_reset <= 1'b1;
        cyc(30);
        i_key_reset <= 1'b0;
        cyc(4);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            i_pulse_a <= 1'b1;
            i_pulse_b <= b_on;
            cyc(4);
            i_pulse_a <= 1'b0;
            i_pulse_b <= 1'b0;
            cyc(6);
        end
    endtask
    task automatic press_stop;
        i_key_stop <= 1'b1;
        cyc(5);
        i_key_stop <= 1'b0;
        cyc(3);
    endtask
    // Bounded wait for a whole ticket: request up, then printer done
    task automatic wait_print;
        int k;
        k = 0;
        while (o_print_req !== 1'b1 && k < 2000) begin
            cyc(1);
            k++;
        end
        if (o_print_req === 1'b1) begin
            k = 0;
            while (o_print_req === 1'b1 && k < 2000) begin
                cyc(1);
                k++;
            end
        end
        if (o_print_req !== 1'b0 || k >= 2000) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, k, 0);
            test_done();
        end else begin
            cyc(2);
        end
    endtask
    initial begin
        cyc(10);
        i_rst <= 1'b0;
        cyc(2);
        check(o_eod, 1'b0);
        start_del();
        check({o_relay1, o_relay2}, 2'b10);
        check(o_delivery_no, 16'h1);
        pulses(5);
        press_stop();
        check(o_relay1, 1'b0);
        wait_print();
        check(o_gross_total, 32'h5);
        check(o_eod, 1'b1);
        $display("start/stop delivery done");
        press_stop();
        check(o_print_duplicate, 1'b1);
        wait_print();
        $display("duplicate ticket done");
        pulses(3);
        check(o_delivery_no, 16'h2);
        check({o_relay1, o_reset_led}, 2'b01);
        press_stop();
        wait_print();
        $display("auto reset done");
        i_preset_mode <= 1'b1;
        i_batch_on_net <= 1'b1;
        start_del();
        check(o_net_total, 32'h0);
        pulses(6);
        check({o_relay1, o_relay2}, 2'b00);
        check(o_eod, 1'b0);
        wait_print();
        check(o_eod, 1'b1);
        $display("preset batch done");
        i_preset_mode <= 1'b0;
        i_batch_on_net <= 1'b0;
        i_noflow_timer_en <= 1'b0;
        start_del();
        cyc(300);
        check(o_eod, 1'b0);
        i_noflow_timer_en <= 1'b1;
        wait_print();
        check({o_eod, o_delivery_no}, {1'b1, 16'h4});
        $display("no-flow timer done");
        i_clear_min <= 7'h32;
        start_del();
        pulses(3);
        press_stop();
        cyc(100);
        check(o_print_req, 1'b0);
        check(o_gross_total, 32'h0);
        press_stop();
        check(o_no_delivery_message, 1'b1);
        i_clear_min <= 7'h00;
        $display("clearable minimum done");
        start_del();
        i_probe_fault <= 1'b1;
        cyc(6);
        check({o_relay1, o_fault_active}, 2'b01);
        i_dual_input <= 1'b1;
        b_on <= 1'b0;
        pulses(2);
        check(o_gross_total, 32'h2);
        check(o_fault_code_display, 8'h03);
        i_probe_fault <= 1'b0;
        i_dual_input <= 1'b0;
        b_on <= 1'b1;
        press_stop();
        wait_print();
        $display("probe fault done");
        start_del();
        pulses(2);
        i_power_good <= 1'b0;
        cyc(6);
        check({o_eod, o_print_req}, 2'b10);
        i_power_good <= 1'b1;
        cyc(4);
        check({o_print_req, o_print_duplicate}, 2'b10);
        wait_print();
        press_stop();
        check({o_print_req, o_print_duplicate}, 2'b11);
        wait_print();
        $display("power loss done");
        delay <= 8'hc8;
        start_del();
        pulses(2);
        press_stop();
        cyc(40);
        pulses(3);
        check(o_fault_code_display, delivery_pkg::FAULT_OVERFLOW);
        wait_print();
        check(o_ticket_status, delivery_pkg::OVERFLOW_STATUS);
        check(o_fault_active, 1'b0);
        check(o_gross_total, 32'h2);
        check(o_acc_total, 32'h16);
        $display("overflow done");
        test_done();
    end
endmodule
`default_nettype wire
